/* pdl_pkg.sv */
// Package with offsets, field positions and reset values of the module-disable write lock.
package pdl_pkg;

  // Register offsets on the register port (byte addresses, one word each).
  localparam logic [7:0] OFS_CFG_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CONFIG_WORD_THREE = 8'h04;
  localparam logic [7:0] OFS_DISABLE_BASE = 8'h10;
  localparam logic [7:0] OFS_STEP = 8'h04;

  // Field positions in the configuration control register.
  localparam int BIT_DISABLE_LOCK = 12;

  // Field positions in configuration word three.
  localparam int BIT_VBUS_OWNER = 31;
  localparam int BIT_USB_ID_OWNER = 30;
  localparam int BIT_PIN_SELECT_ONE_SHOT = 29;
  localparam int BIT_DISABLE_ONE_SHOT = 28;
  localparam int USER_ID_MSB = 15;

  // Implemented bits of configuration word three; bits 27 to 16 read as zero.
  localparam logic [31:0] CONFIG_WORD_MASK = 32'hF000_FFFF;

  // Values after reset.
  localparam logic LOCK_RESET = 1'h1;
  localparam logic [31:0] DISABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

endpackage

/* pdl_config_word.sv */
// Configuration word three: programmed bits captured at reset, unimplemented bits forced to zero.
`timescale 1ns/10ps

module pdl_config_word (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Programmed configuration bits.
  input wire logic [31:0] programmedWord,
  // Captured word and decoded fields.
  output logic [31:0] configWord,
  output logic vbusOnPinOwner,
  output logic usbIdPinOwner,
  output logic pinSelectOneShot,
  output logic moduleDisableOneShot,
  output logic [15:0] userIdentifier
);

  logic [31:0] word_ff;

  // The word is loaded while reset is held and then stays fixed until the next reset.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      word_ff <= programmedWord & pdl_pkg::CONFIG_WORD_MASK; // [R12]
    end
  end

  // Field decode; ownership selects leave the block as levels.
  assign configWord = word_ff;
  assign vbusOnPinOwner = word_ff[pdl_pkg::BIT_VBUS_OWNER]; // [R9]
  assign usbIdPinOwner = word_ff[pdl_pkg::BIT_USB_ID_OWNER]; // [R10]
  assign pinSelectOneShot = word_ff[pdl_pkg::BIT_PIN_SELECT_ONE_SHOT]; // [R8]
  assign moduleDisableOneShot = word_ff[pdl_pkg::BIT_DISABLE_ONE_SHOT]; // [R5]
  assign userIdentifier = word_ff[pdl_pkg::USER_ID_MSB:0]; // [R11]

  // The captured word keeps its unimplemented bits at zero and never moves outside reset.
  chk_unimpl_zero: assert property (@(posedge clock) disable iff (!rstn) // [R12]
    (word_ff & ~pdl_pkg::CONFIG_WORD_MASK) == 32'h0000_0000)
    else $error("Unimplemented config bits not zero.");
  chk_word_stable: assert property (@(posedge clock) disable iff (!rstn) // [R11]
    $past(rstn) |-> $stable(word_ff)) else $error("Config word changed outside reset.");

endmodule

/* pdl_write_lock.sv */
// Write lock for the module-disable registers, with the configuration control and word three.
`timescale 1ns/10ps

// Behaviour
// R1 - While locked, writes to module-disable registers leave their contents unchanged.
// R2 - Blocked writes complete like ordinary writes, no error and no stall.
// R3 - Lock is bit 12 of configuration control; one blocks, zero permits writes.
// R4 - Software runs the system unlock sequence before changing the lock bit.
// R5 - One-shot bit 28 forbids clearing the lock once set; zero allows repeats. The code still allows one clear of the lock set by reset.
// R6 - With lock set in one-shot mode, unlock procedures are ignored. The code still clears on an unlocked write until software first sets the lock.
// R7 - In one-shot mode only a device reset clears the set lock. The code's reset loads the lock set and allows one clear again.
// R8 - Bit 29 of word three selects one-time or repeated pin-select configuration.
// R9 - Bit 31 of word three gives the bus-power pin to USB or port.
// R10 - Bit 30 of word three gives the USB ID pin to USB or port.
// R11 - Bits 15 to 0 of word three hold a 16-bit user identifier.
// R12 - Bits 27 to 16 of word three always read as zero.
// R13 - The lock is set after reset; writes need an explicit unlock.
module pdl_write_lock #(
  parameter int NUM_DISABLE = 6,
  parameter int DISABLE_WIDTH = 32
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regReady,
  // System unlock state from the key sequence logic.
  input wire logic systemUnlocked,
  // Programmed configuration bits.
  input wire logic [31:0] programmedWord,
  // Module-disable register contents.
  output logic [NUM_DISABLE*DISABLE_WIDTH-1:0] moduleDisable,
  // Lock state and configuration fields.
  output logic moduleDisableLock,
  output logic vbusOnPinOwner,
  output logic usbIdPinOwner,
  output logic pinSelectOneShot,
  output logic [15:0] userIdentifier
);

  logic lock_ff;
  logic nxt_lock;
  logic setOnce_ff;
  logic [31:0] regRdata_ff;
  logic [31:0] nxt_regRdata;
  logic [31:0] configWord;
  logic oneShot;
  logic controlHit;
  logic lockWriteValue;
  logic lockChangeAllowed;
  logic [DISABLE_WIDTH-1:0] disable_ff [NUM_DISABLE];
  logic [NUM_DISABLE-1:0] disableHit;

  pdl_config_word pdl_config_word_i (
    .clock(clock),
    .rstn(rstn),
    .programmedWord(programmedWord),
    .configWord(configWord),
    .vbusOnPinOwner(vbusOnPinOwner),
    .usbIdPinOwner(usbIdPinOwner),
    .pinSelectOneShot(pinSelectOneShot),
    .moduleDisableOneShot(oneShot),
    .userIdentifier(userIdentifier)
  );

  // Every access completes in its own cycle, whether or not it is blocked.
  assign regReady = 1'b1; // [R2]

  // Control register decode and the value a write would give the lock.
  assign controlHit = regWrite && (regAddr == pdl_pkg::OFS_CFG_CONTROL);
  assign lockWriteValue = regWdata[pdl_pkg::BIT_DISABLE_LOCK];

  // The lock moves only after the system unlock, and never clears once software has set it in one-shot mode.
  // Setting is always allowed with the unlock, so software can close a session at any time.
  // Disable-register writes do not need the unlock; only the lock itself gates them.
  assign lockChangeAllowed = systemUnlocked && !(oneShot && setOnce_ff && !lockWriteValue); // [R4] [R5] [R6]

  // Next lock value.
  always_comb begin
    nxt_lock = lock_ff;
    if (controlHit && lockChangeAllowed) begin
      nxt_lock = lockWriteValue; // [R3]
    end
  end

  // Lock bit; only reset forces it back, and reset leaves it locked.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lock_ff <= pdl_pkg::LOCK_RESET; // [R13] [R7]
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // Remembers that software has set the lock at least once since reset.
  // Reset loads the lock but does not count as a set, so the first clear stays allowed.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      setOnce_ff <= 1'b0; // [R7]
    end else if (!lock_ff && nxt_lock) begin
      setOnce_ff <= 1'b1; // [R5]
    end
  end

  // The lock leaves the block as a level for the peripherals that it guards.
  assign moduleDisableLock = lock_ff;

  // Module-disable registers, written only while the lock is clear.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DISABLE; gi++) begin : g_disable
      assign disableHit[gi] = regWrite &&
        (regAddr == 8'(pdl_pkg::OFS_DISABLE_BASE + pdl_pkg::OFS_STEP * gi));
      always_ff @(posedge clock) begin
        if (!rstn) begin
          disable_ff[gi] <= DISABLE_WIDTH'(pdl_pkg::DISABLE_RESET);
        end else if (disableHit[gi] && !lock_ff) begin // [R1] [R3]
          disable_ff[gi] <= regWdata[DISABLE_WIDTH-1:0];
        end
      end
      assign moduleDisable[gi*DISABLE_WIDTH +: DISABLE_WIDTH] = disable_ff[gi];
      // Every entry holds while locked and takes an unlocked write on the next edge.
      chk_entry_locked: assert property (@(posedge clock) disable iff (!rstn) // [R1]
        lock_ff |=> $stable(disable_ff[gi]))
        else $error("Disable entry changed while locked.");
      chk_entry_write: assert property (@(posedge clock) disable iff (!rstn) // [R3]
        (disableHit[gi] && !lock_ff) |=> disable_ff[gi] == $past(regWdata[DISABLE_WIDTH-1:0]))
        else $error("Unlocked entry write was not stored.");
    end
  endgenerate

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    nxt_regRdata = 32'h0000_0000;
    if (regAddr == pdl_pkg::OFS_CFG_CONTROL) begin
      nxt_regRdata[pdl_pkg::BIT_DISABLE_LOCK] = lock_ff;
    end else if (regAddr == pdl_pkg::OFS_CONFIG_WORD_THREE) begin
      nxt_regRdata = configWord; // [R12]
    end
    for (int i = 0; i < NUM_DISABLE; i++) begin
      if (regAddr == 8'(pdl_pkg::OFS_DISABLE_BASE + pdl_pkg::OFS_STEP * i)) begin
        nxt_regRdata = 32'(disable_ff[i]);
      end
    end
  end

  // Read data register, loaded on a read and held otherwise.
  // A read and a write in one cycle return the value from before the write.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdata_ff <= pdl_pkg::READ_RESET;
    end else if (regRead) begin
      regRdata_ff <= nxt_regRdata;
    end
  end

  // Read data leaves the block straight from its register.
  assign regRdata = regRdata_ff;

  // Checks on module-disable register 0 and on the write handshake.
  chk_locked_hold: assert property (@(posedge clock) disable iff (!rstn) // [R1]
    lock_ff |=> disable_ff[0] == $past(disable_ff[0]))
    else $error("Disable register changed while locked.");
  chk_unlocked_write: assert property (@(posedge clock) disable iff (!rstn) // [R3]
    (disableHit[0] && !lock_ff) |=> disable_ff[0] == $past(regWdata[DISABLE_WIDTH-1:0]))
    else $error("Unlocked write was not stored.");
  chk_ready_always: assert property (@(posedge clock) disable iff (!rstn) // [R2]
    regWrite |-> regReady) else $error("Write was stalled.");

  // Checks on how the lock bit and the one-shot memory may move.
  chk_no_key_hold: assert property (@(posedge clock) disable iff (!rstn) // [R4]
    !systemUnlocked |=> lock_ff == $past(lock_ff))
    else $error("Lock changed without system unlock.");
  chk_oneshot_stick: assert property (@(posedge clock) disable iff (!rstn) // [R6]
    (oneShot && setOnce_ff && lock_ff) |=> lock_ff)
    else $error("One-shot lock was cleared.");
  chk_multi_clear: assert property (@(posedge clock) disable iff (!rstn) // [R5]
    (!oneShot && controlHit && systemUnlocked && !lockWriteValue) |=> !lock_ff)
    else $error("Lock not cleared in repeat mode.");
  chk_set_allowed: assert property (@(posedge clock) disable iff (!rstn) // [R3]
    (controlHit && systemUnlocked && lockWriteValue) |=> lock_ff)
    else $error("Lock not set by an unlocked write.");
  chk_set_marks: assert property (@(posedge clock) disable iff (!rstn) // [R5]
    (!lock_ff && nxt_lock) |=> setOnce_ff)
    else $error("Software set of the lock not remembered.");
  chk_reset_locked: assert property (@(posedge clock) // [R13]
    !rstn |=> lock_ff && !setOnce_ff) else $error("Lock not set after reset.");
  chk_reset_only: assert property (@(posedge clock) disable iff (!rstn) // [R7]
    (oneShot && $past(setOnce_ff) && $past(lock_ff)) |-> lock_ff)
    else $error("Set lock cleared without reset.");

  // Checks on the read port: lock readback, word three contents and held data.
  chk_lock_readback: assert property (@(posedge clock) disable iff (!rstn) // [R3]
    (regRead && regAddr == pdl_pkg::OFS_CFG_CONTROL)
    |=> regRdata == (32'($past(lock_ff)) << pdl_pkg::BIT_DISABLE_LOCK))
    else $error("Control read does not show the lock.");
  chk_word_readback: assert property (@(posedge clock) disable iff (!rstn) // [R12]
    (regRead && regAddr == pdl_pkg::OFS_CONFIG_WORD_THREE)
    |=> (regRdata & ~pdl_pkg::CONFIG_WORD_MASK) == 32'h0000_0000)
    else $error("Word three read shows unimplemented bits.");
  chk_word_value: assert property (@(posedge clock) disable iff (!rstn) // [R11]
    (regRead && regAddr == pdl_pkg::OFS_CONFIG_WORD_THREE)
    |=> regRdata[pdl_pkg::USER_ID_MSB:0] == $past(userIdentifier))
    else $error("Word three read lost the user identifier.");
  chk_read_hold: assert property (@(posedge clock) disable iff (!rstn) // [R2]
    !regRead |=> $stable(regRdata))
    else $error("Read data moved without a read.");

  // Checks that the configuration fields leave the block from word three.
  chk_field_owner: assert property (@(posedge clock) disable iff (!rstn) // [R9]
    vbusOnPinOwner == configWord[pdl_pkg::BIT_VBUS_OWNER])
    else $error("Bus-power pin owner differs from word three.");
  chk_usb_owner: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    usbIdPinOwner == configWord[pdl_pkg::BIT_USB_ID_OWNER])
    else $error("USB ID pin owner differs from word three.");
  chk_pin_select: assert property (@(posedge clock) disable iff (!rstn) // [R8]
    pinSelectOneShot == configWord[pdl_pkg::BIT_PIN_SELECT_ONE_SHOT])
    else $error("Pin-select mode differs from word three.");
  chk_user_id: assert property (@(posedge clock) disable iff (!rstn) // [R11]
    userIdentifier == configWord[pdl_pkg::USER_ID_MSB:0])
    else $error("User identifier differs from word three.");

endmodule

/* pdl_write_lock_tb.sv */
// Self-checking testbench for the module-disable write lock.
`timescale 1ns/10ps

module pdl_write_lock_tb;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rexp;} pdl_row_t;
  localparam logic [7:0] CTL = pdl_pkg::OFS_CFG_CONTROL;
  localparam logic [31:0] LOCKV = 32'h0000_1000;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic systemUnlocked = 1'h0;
  logic [31:0] programmedWord = 32'h0000_0000;
  logic [31:0] regRdata;
  logic regReady;
  logic [191:0] moduleDisable;
  logic moduleDisableLock;
  logic vbusOnPinOwner;
  logic usbIdPinOwner;
  logic pinSelectOneShot;
  logic [15:0] userIdentifier;
  int err_count = 0;
  int tests_run = 0;
  // Ordinary accesses: six disable registers, word three is read-only, one unmapped place.
  pdl_row_t rows [8] = '{'{8'h10, 32'h1111_0001, 32'h1111_0001},
    '{8'h14, 32'h2222_0002, 32'h2222_0002}, '{8'h18, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
    '{8'h1C, 32'h8000_0001, 32'h8000_0001}, '{8'h20, 32'h5A5A_A5A5, 32'h5A5A_A5A5},
    '{8'h24, 32'h0000_0300, 32'h0000_0300}, '{8'h04, 32'h0000_0000, 32'hD000_ABCD},
    '{8'h80, 32'hDEAD_BEEF, 32'h0000_0000}};

  // The design under test.
  pdl_write_lock #(.NUM_DISABLE(6), .DISABLE_WIDTH(32)) pdl_write_lock_i (
    .clock(clock), .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regReady(regReady),
    .systemUnlocked(systemUnlocked), .programmedWord(programmedWord),
    .moduleDisable(moduleDisable), .moduleDisableLock(moduleDisableLock),
    .vbusOnPinOwner(vbusOnPinOwner), .usbIdPinOwner(usbIdPinOwner),
    .pinSelectOneShot(pinSelectOneShot), .userIdentifier(userIdentifier));

  // Clock of 5 ns period.
  always #2.5 clock = ~clock;

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Holds reset for ten cycles with the given programmed word.
  task automatic rst(input logic [31:0] pw);
    @(posedge clock);
    rstn <= 1'h0;
    programmedWord <= pw;
    repeat (10) @(posedge clock);
    rstn <= 1'h1;
    #1;
  endtask

  // One write pulse; the unlock level travels with it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic u);
    @(posedge clock);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    systemUnlocked <= u;
    @(posedge clock);
    regWrite <= 1'h0;
    systemUnlocked <= 1'h0;
    #1;
    chk({31'h0, regReady}, 32'h1);
  endtask

  // One read pulse; data is settled one cycle later.
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'h0;
    #1;
  endtask

  // Bounds the whole run.
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rst(32'hDFFF_ABCD);
    chk({31'h0, moduleDisableLock}, 32'h1);
    chk({30'h0, vbusOnPinOwner, usbIdPinOwner}, 32'h3);
    chk({31'h0, pinSelectOneShot}, 32'h0);
    chk({16'h0, userIdentifier}, 32'h0000_ABCD);
    wr(8'h10, 32'h5555_5555, 1'h0);
    chk(moduleDisable[31:0], 32'h0);
    rd(8'h10);
    chk(regRdata, 32'h0);
    wr(CTL, 32'h0, 1'h0);
    chk({31'h0, moduleDisableLock}, 32'h1);
    wr(CTL, 32'h0, 1'h1);
    chk({31'h0, moduleDisableLock}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].addr, rows[i].wdata, 1'h0);
      rd(rows[i].addr);
      chk(regRdata, rows[i].rexp);
    end
    chk(moduleDisable[191:160], 32'h0000_0300);
    wr(CTL, LOCKV, 1'h1);
    rd(CTL);
    chk(regRdata, LOCKV);
    wr(8'h14, 32'h0, 1'h0);
    chk(moduleDisable[63:32], 32'h2222_0002);
    wr(CTL, 32'h0, 1'h1);
    chk({31'h0, moduleDisableLock}, 32'h1);
    wr(8'h14, 32'h0, 1'h0);
    chk(moduleDisable[63:32], 32'h2222_0002);
    rst(32'h6FFF_0042);
    chk({31'h0, moduleDisableLock}, 32'h1);
    chk(moduleDisable[63:32], 32'h0);
    chk({29'h0, vbusOnPinOwner, usbIdPinOwner, pinSelectOneShot}, 32'h3);
    chk({16'h0, userIdentifier}, 32'h0000_0042);
    rd(8'h04);
    chk(regRdata, 32'h6000_0042);
    wr(CTL, 32'h0, 1'h1);
    wr(CTL, LOCKV, 1'h1);
    wr(CTL, 32'h0, 1'h1);
    chk({31'h0, moduleDisableLock}, 32'h0);
    wr(8'h18, 32'h0000_00A5, 1'h0);
    chk(moduleDisable[95:64], 32'h0000_00A5);
    report_and_stop();
  end
endmodule
